//--- rtl/dfu_cmd_pkg.sv
// Purpose: Shared constants and types of the firmware-upgrade command interpreter.
// Assumes: APB register map with one 32-bit word per register.
// Notes:   Status codes follow the upgrade-class status numbering.
package dfu_cmd_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0]  REG_FRAME0   = 8'h00;
	localparam logic [7:0]  REG_FRAME1   = 8'h04;
	localparam logic [7:0]  REG_REQUEST  = 8'h08;
	localparam logic [7:0]  REG_STATUS   = 8'h0C;
	localparam logic [7:0]  REG_UPLOAD   = 8'h10;

	// ------------------------------------------------------------
	// Host request codes and command frame values
	// ------------------------------------------------------------
	localparam logic [2:0]  REQ_DNLOAD   = 3'h1;
	localparam logic [2:0]  REQ_GETSTAT  = 3'h3;
	localparam logic [2:0]  REQ_CLRSTAT  = 3'h4;
	localparam logic [7:0]  CMD_DISPLAY  = 8'h03;
	localparam logic [7:0]  CMD_WRITE    = 8'h04;
	localparam logic [7:0]  CMD_READ     = 8'h05;
	localparam logic [7:0]  SUB_00       = 8'h00;
	localparam logic [7:0]  SUB_01       = 8'h01;
	localparam logic [7:0]  SUB_02       = 8'h02;
	localparam logic [7:0]  SUB_03       = 8'h03;
	localparam logic [7:0]  SEL_CFG_LAST = 8'h06;
	localparam logic [7:0]  SEL_MANUF    = 8'h30;
	localparam logic [7:0]  SEL_FAMILY   = 8'h31;
	localparam logic [7:0]  SEL_PRODUCT  = 8'h60;
	localparam logic [7:0]  SEL_REVISION = 8'h61;
	localparam logic [7:0]  SEL_BLOCK1   = 8'h20;
	localparam logic [7:0]  SEL_BLOCK2   = 8'h40;
	localparam logic [7:0]  SEL_FULL     = 8'hFF;
	localparam logic [7:0]  LEN_LONG_JMP = 8'h05;

	// ------------------------------------------------------------
	// Status codes, memory bounds, configuration store
	// ------------------------------------------------------------
	localparam logic [3:0]  STAT_OK         = 4'h0;
	localparam logic [3:0]  STAT_ERR_WRITE  = 4'h3;
	localparam logic [3:0]  STAT_NOT_ERASED = 4'h5;
	localparam logic [3:0]  STAT_ERR_VENDOR = 4'hB;
	localparam logic [3:0]  STAT_ERR_STALL  = 4'hF;
	localparam logic [15:0] BLK0_FIRST   = 16'h0000;
	localparam logic [15:0] BLK0_LAST    = 16'h1FFF;
	localparam logic [15:0] BLK1_FIRST   = 16'h2000;
	localparam logic [15:0] BLK1_LAST    = 16'h3FFF;
	localparam logic [15:0] BLK2_FIRST   = 16'h4000;
	localparam logic [15:0] BLK2_LAST    = 16'h7FFF;
	localparam logic [15:0] START_ADDR   = 16'h0000;
	localparam logic [7:0]  ERASED_BYTE  = 8'hFF;
	localparam logic [2:0]  CFG_BOOT_STATUS = 3'd0;
	localparam logic [2:0]  CFG_BOOT_VECTOR = 3'd1;
	localparam logic [2:0]  CFG_SECURITY    = 3'd5;
	localparam logic [2:0]  STEP_ERASE   = 3'd3;
	localparam logic [2:0]  STEP_WAIT    = 3'd4;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'b000,
		ST_DN_IDLE  = 3'b001,
		ST_BUSY     = 3'b010,
		ST_UP_IDLE  = 3'b011,
		ST_ERROR    = 3'b100,
		ST_ARMED    = 3'b101,
		ST_LAUNCHED = 3'b110
	} state_t;

	typedef enum logic [2:0] {
		OP_NONE    = 3'b000,
		OP_DISPLAY = 3'b001,
		OP_BLANK   = 3'b010,
		OP_CFGRD   = 3'b011,
		OP_BYTE    = 3'b100,
		OP_ERASE   = 3'b101
	} op_t;

endpackage : dfu_cmd_pkg

//--- rtl/cfg_byte_store.sv
// Purpose: Small store for the configuration bytes.
// Assumes: One write and one read port, both on pclk.
// Notes:   Read data is registered, so it lags the read address by one cycle.
`timescale 1ns/1ps
module cfg_byte_store
	import dfu_cmd_pkg::*;
#(
	parameter int AW = 3,
	parameter int DW = 8
)(
	// Clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// Write port
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata,
	// Read port
	input  wire logic [AW-1:0] raddr,
	output logic      [DW-1:0] rdata
);

	logic [DW-1:0] mem_ff [2**AW];

	// Erased bytes mean no security after reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < 2**AW; i++)
				mem_ff[i] <= '1;
			rdata <= '1;
		end
		else
		begin
			if (we)
				mem_ff[waddr] <= wdata;
			rdata <= mem_ff[raddr];
		end
	end

endmodule : cfg_byte_store

//--- rtl/dfu_memory_command_interpreter.sv
// Purpose: Decodes upgrade command frames and runs memory and configuration operations.
// Assumes: Frames and requests are written over APB by the USB firmware.
// Notes:   Flash reads and erases go through simple request/acknowledge ports.
`timescale 1ns/1ps
module dfu_memory_command_interpreter
	import dfu_cmd_pkg::*;
#(
	parameter logic [7:0] LOADER_VERSION = 8'h01,  // Arbitrary value
	parameter logic [7:0] BOOT_ID1       = 8'h11,  // Arbitrary value
	parameter logic [7:0] BOOT_ID2       = 8'h22,  // Arbitrary value
	parameter logic [7:0] MANUF_CODE     = 8'h5A,  // Arbitrary value
	parameter logic [7:0] FAMILY_CODE    = 8'h33,  // Arbitrary value
	parameter logic [7:0] PRODUCT_CODE   = 8'h44,  // Arbitrary value
	parameter logic [7:0] REVISION_CODE  = 8'h55,  // Arbitrary value
	parameter logic [7:0] HSB_RESET      = 8'hFF
)(
	// APB slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Memory read port
	output logic             mem_req,
	output logic             mem_space,
	output logic      [15:0] mem_addr,
	input  wire logic [7:0]  mem_rdata,
	input  wire logic        mem_ack,
	// Flash erase port
	output logic             erase_req,
	output logic      [15:0] erase_first,
	output logic      [15:0] erase_last,
	input  wire logic        erase_done,
	// Application start
	output logic             wdt_enable,
	output logic             jump_req,
	output logic      [15:0] jump_addr
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	state_t      state_ff,  nxt_state;
	op_t         op_ff,     nxt_op;
	logic [3:0]  pend_ff,   nxt_pend;
	logic [3:0]  rep_ff,    nxt_rep;
	logic [15:0] cur_ff,    nxt_cur;
	logic [15:0] end_ff,    nxt_end;
	logic [15:0] fail_ff,   nxt_fail;
	logic [7:0]  byte_ff,   nxt_byte;
	logic [7:0]  hsb_ff,    nxt_hsb;
	logic [2:0]  step_ff,   nxt_step;
	logic [31:0] frame0_ff, nxt_frame0;
	logic [15:0] frame1_ff, nxt_frame1;
	logic [31:0] rdat_ff,   nxt_rdat;
	logic [15:0] efirst_ff, nxt_efirst;
	logic [15:0] elast_ff,  nxt_elast;
	logic [15:0] jaddr_ff,  nxt_jaddr;
	logic        space_ff,  nxt_space;
	logic        prot_ff,   nxt_prot;
	logic        mreq_ff,   nxt_mreq;
	logic        ereq_ff,   nxt_ereq;
	logic        wdt_ff,    nxt_wdt;
	logic        jump_ff,   nxt_jump;
	logic        slow_ff,   nxt_slow;
	logic        resp_ff,   nxt_resp;

	logic        acc;
	logic        done;
	logic        req_wr;
	logic        dn_go;
	logic        up_rd;
	logic        mapped;
	logic [7:0]  cmd_id;
	logic [7:0]  d0;
	logic [7:0]  d1;
	logic [7:0]  d2;
	logic [7:0]  d3;
	logic [7:0]  req_len;
	logic        cfg_we;
	logic [2:0]  cfg_wa;
	logic [7:0]  cfg_wd;
	logic [7:0]  cfg_rdata;
	logic [31:0] rd_word;

	assign cmd_id  = frame0_ff[7:0];
	assign d0      = frame0_ff[15:8];
	assign d1      = frame0_ff[23:16];
	assign d2      = frame0_ff[31:24];
	assign d3      = frame1_ff[7:0];
	assign req_len = pwdata[15:8];

	cfg_byte_store #(.AW(3), .DW(8)) u_cfg (
		.pclk    (pclk),
		.presetn (presetn),
		.we      (cfg_we),
		.waddr   (cfg_wa),
		.wdata   (cfg_wd),
		.raddr   (d1[2:0]),
		.rdata   (cfg_rdata)
	);

	// ------------------------------------------------------------
	// APB handshake
	// ------------------------------------------------------------
	always_comb
	begin
		acc    = psel && penable;
		mapped = (paddr == REG_FRAME0) || (paddr == REG_FRAME1) || (paddr == REG_REQUEST)
			|| (paddr == REG_STATUS) || (paddr == REG_UPLOAD);
		pready = 1'b1;
		// Status is only answered once an erase or blank check has finished
		if (acc && pwrite && paddr == REG_REQUEST && pwdata[2:0] == REQ_GETSTAT
			&& state_ff == ST_BUSY)
			pready = 1'b0;
		if (acc && !pwrite && paddr == REG_UPLOAD && slow_ff && !resp_ff)
			pready = 1'b0;
		pslverr = acc && !mapped;
		done    = acc && pready;
		req_wr  = done && pwrite && paddr == REG_REQUEST;
		up_rd   = done && !pwrite && paddr == REG_UPLOAD;
		dn_go   = req_wr && pwdata[2:0] == REQ_DNLOAD && req_len != 8'h00
			&& (state_ff == ST_IDLE || state_ff == ST_DN_IDLE || state_ff == ST_UP_IDLE);
	end

	always_comb
	begin
		rd_word = 32'h0000_0000;
		unique case (paddr)
			REG_FRAME0: rd_word = frame0_ff;
			REG_FRAME1: rd_word = {16'h0000, frame1_ff};
			REG_STATUS: rd_word = {16'h0000, hsb_ff, prot_ff, state_ff, rep_ff};
			REG_UPLOAD:
			begin
				if (op_ff == OP_BLANK)
					rd_word = {16'h0000, fail_ff};
				else if (op_ff == OP_CFGRD)
					rd_word = {24'h000000, cfg_rdata};
				else if (op_ff == OP_BYTE)
					rd_word = {24'h000000, byte_ff};
			end
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// ------------------------------------------------------------
	// Command engine
	// ------------------------------------------------------------
	always_comb
	begin
		nxt_state = state_ff;   nxt_op = op_ff;       nxt_pend = pend_ff;
		nxt_rep = rep_ff;       nxt_cur = cur_ff;     nxt_end = end_ff;
		nxt_fail = fail_ff;     nxt_byte = byte_ff;   nxt_hsb = hsb_ff;
		nxt_step = step_ff;     nxt_frame0 = frame0_ff;
		nxt_frame1 = frame1_ff; nxt_rdat = rdat_ff;   nxt_efirst = efirst_ff;
		nxt_elast = elast_ff;   nxt_jaddr = jaddr_ff; nxt_space = space_ff;
		nxt_prot = prot_ff;     nxt_mreq = mreq_ff;   nxt_wdt = wdt_ff;
		nxt_slow = slow_ff;     nxt_resp = resp_ff;
		nxt_ereq = 1'b0;
		nxt_jump = 1'b0;
		cfg_we = 1'b0;
		cfg_wa = d1[2:0];
		cfg_wd = d2;

		// Read data is settled in the setup phase so zero-wait reads work
		if (psel && !penable && !pwrite)
		begin
			nxt_rdat = rd_word;
			nxt_slow = paddr == REG_UPLOAD && state_ff == ST_UP_IDLE && op_ff == OP_DISPLAY;
		end
		if (done && pwrite && paddr == REG_FRAME0)
			nxt_frame0 = pwdata;
		if (done && pwrite && paddr == REG_FRAME1)
			nxt_frame1 = pwdata[15:0];

		if (state_ff == ST_BUSY && op_ff == OP_BLANK)
		begin
			if (!mreq_ff)
				nxt_mreq = 1'b1;
			else if (mem_ack)
			begin
				nxt_mreq = 1'b0;
				if (mem_rdata != ERASED_BYTE)
				begin
					nxt_fail  = cur_ff;
					nxt_pend  = STAT_NOT_ERASED;
					nxt_state = ST_DN_IDLE;
				end
				else if (cur_ff == end_ff)
				begin
					nxt_pend  = STAT_OK;
					nxt_state = ST_DN_IDLE;
				end
				else
					nxt_cur = cur_ff + 16'h0001;
			end
		end
		if (state_ff == ST_BUSY && op_ff == OP_ERASE)
		begin
			// Full erase first restores boot status, boot vector and security
			if (step_ff < STEP_ERASE)
			begin
				cfg_we = 1'b1;
				cfg_wd = ERASED_BYTE;
				cfg_wa = (step_ff == 3'd0) ? CFG_BOOT_STATUS
					: (step_ff == 3'd1) ? CFG_BOOT_VECTOR : CFG_SECURITY;
				nxt_prot = 1'b0;
				nxt_step = step_ff + 3'd1;
			end
			else if (step_ff == STEP_ERASE)
			begin
				nxt_ereq = 1'b1;
				nxt_step = STEP_WAIT;
			end
			else if (erase_done)
			begin
				nxt_pend  = STAT_OK;
				nxt_state = ST_DN_IDLE;
				nxt_op    = OP_NONE;
			end
		end

		// Display stream: one memory byte per upload read
		if (state_ff == ST_UP_IDLE && slow_ff)
		begin
			if (acc && !mreq_ff && !resp_ff)
				nxt_mreq = 1'b1;
			else if (mreq_ff && mem_ack)
			begin
				nxt_mreq = 1'b0;
				nxt_resp = 1'b1;
				nxt_rdat = {24'h000000, mem_rdata};
				if (cur_ff == end_ff)
				begin
					nxt_state = ST_IDLE;
					nxt_op    = OP_NONE;
				end
				else
					nxt_cur = cur_ff + 16'h0001;
			end
		end
		if (done && slow_ff)
		begin
			nxt_resp = 1'b0;
			nxt_slow = 1'b0;
		end
		if (up_rd && state_ff == ST_UP_IDLE && (op_ff == OP_CFGRD || op_ff == OP_BYTE))
		begin
			nxt_state = ST_IDLE;
			nxt_op    = OP_NONE;
		end

		if (dn_go)
		begin
			nxt_state = ST_DN_IDLE;
			nxt_op    = OP_NONE;
			nxt_pend  = STAT_ERR_STALL;
			nxt_cur   = {d1, d2};
			nxt_end   = {d3, frame1_ff[15:8]};
			nxt_step  = 3'd0;
			unique case (cmd_id)
				CMD_DISPLAY:
				begin
					nxt_space = d0 == SUB_02;
					if (d0 == SUB_00 || d0 == SUB_02)
					begin
						nxt_op   = OP_DISPLAY;
						nxt_pend = STAT_OK;
					end
					else if (d0 == SUB_01)
					begin
						nxt_op    = OP_BLANK;
						nxt_state = ST_BUSY;
						nxt_space = 1'b0;
					end
				end
				CMD_WRITE:
				begin
					if (d0 == SUB_01 && d1 <= SEL_CFG_LAST)
					begin
						nxt_pend = prot_ff ? STAT_ERR_WRITE : STAT_OK;
						if (!prot_ff)
						begin
							cfg_we = 1'b1;
							if (d1[2:0] == CFG_SECURITY)
								nxt_prot = d2 != ERASED_BYTE;
						end
					end
					else if (d0 == SUB_02 && d1 == SUB_00)
					begin
						nxt_pend = prot_ff ? STAT_ERR_WRITE : STAT_OK;
						if (!prot_ff)
							nxt_hsb = {d2[7:4], hsb_ff[3:0]};
					end
					else if (d0 == SUB_00 && d1 == SEL_FULL)
					begin
						nxt_op     = OP_ERASE;
						nxt_state  = ST_BUSY;
						nxt_efirst = BLK0_FIRST;
						nxt_elast  = BLK2_LAST;
					end
					else if (d0 == SUB_00 && (d1 == SUB_00 || d1 == SEL_BLOCK1 || d1 == SEL_BLOCK2))
					begin
						nxt_efirst = (d1 == SUB_00) ? BLK0_FIRST
							: (d1 == SEL_BLOCK1) ? BLK1_FIRST : BLK2_FIRST;
						nxt_elast  = (d1 == SUB_00) ? BLK0_LAST
							: (d1 == SEL_BLOCK1) ? BLK1_LAST : BLK2_LAST;
						nxt_pend   = STAT_ERR_WRITE;
						if (!prot_ff)
						begin
							nxt_op    = OP_ERASE;
							nxt_state = ST_BUSY;
							nxt_step  = STEP_ERASE;
						end
					end
					else if (d0 == SUB_03 && (d1 == SUB_00 || d1 == SUB_01))
					begin
						nxt_state = ST_ARMED;
						nxt_pend  = STAT_OK;
						nxt_byte  = d1;
						nxt_jaddr = (d1 == SUB_01 && req_len >= LEN_LONG_JMP)
							? {d2, d3} : START_ADDR;
					end
				end
				CMD_READ:
				begin
					nxt_op = OP_BYTE;
					if (d0 == SUB_00 && d1 <= SUB_02)
						nxt_byte = (d1 == SUB_00) ? LOADER_VERSION
							: (d1 == SUB_01) ? BOOT_ID1 : BOOT_ID2;
					else if (d0 == SUB_02 && d1 == SUB_00)
						nxt_byte = hsb_ff;
					else if (d0 == SUB_01 && d1 <= SEL_CFG_LAST)
						nxt_op = OP_CFGRD;
					else if (d0 == SUB_01 && (d1 == SEL_MANUF || d1 == SEL_FAMILY))
						nxt_byte = (d1 == SEL_MANUF) ? MANUF_CODE : FAMILY_CODE;
					else if (d0 == SUB_01 && (d1 == SEL_PRODUCT || d1 == SEL_REVISION))
						nxt_byte = (d1 == SEL_PRODUCT) ? PRODUCT_CODE : REVISION_CODE;
					else
						nxt_op = OP_NONE;
					if (nxt_op != OP_NONE)
						nxt_pend = prot_ff ? STAT_ERR_VENDOR : STAT_OK;
				end
				default: nxt_pend = STAT_ERR_STALL;
			endcase
		end

		// Empty download after a start command launches the application
		if (req_wr && pwdata[2:0] == REQ_DNLOAD && req_len == 8'h00 && state_ff == ST_ARMED)
		begin
			nxt_state = ST_LAUNCHED;
			if (byte_ff == SUB_00)
				nxt_wdt = 1'b1;
			else
				nxt_jump = 1'b1;
		end
		if (req_wr && pwdata[2:0] == REQ_GETSTAT && state_ff != ST_LAUNCHED
			&& state_ff != ST_ERROR)
		begin
			nxt_rep = pend_ff;
			if (pend_ff != STAT_OK)
				nxt_state = ST_ERROR;
			else if (state_ff == ST_DN_IDLE)
				nxt_state = (op_ff == OP_NONE || op_ff == OP_ERASE) ? ST_IDLE : ST_UP_IDLE;
		end
		if (req_wr && pwdata[2:0] == REQ_CLRSTAT && state_ff != ST_LAUNCHED)
		begin
			nxt_state = ST_IDLE;
			nxt_rep   = STAT_OK;
			nxt_pend  = STAT_OK;
			nxt_op    = OP_NONE;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_ff <= ST_IDLE;      op_ff <= OP_NONE;        pend_ff <= STAT_OK;
			rep_ff <= STAT_OK;        cur_ff <= 16'h0000;      end_ff <= 16'h0000;
			fail_ff <= 16'h0000;      byte_ff <= 8'h00;        hsb_ff <= HSB_RESET;
			step_ff <= 3'd0;          frame0_ff <= 32'h0000_0000;
			frame1_ff <= 16'h0000;    rdat_ff <= 32'h0000_0000;
			efirst_ff <= 16'h0000;    elast_ff <= 16'h0000;    jaddr_ff <= 16'h0000;
			space_ff <= 1'b0;         prot_ff <= 1'b0;         mreq_ff <= 1'b0;
			ereq_ff <= 1'b0;          wdt_ff <= 1'b0;          jump_ff <= 1'b0;
			slow_ff <= 1'b0;          resp_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;    op_ff <= nxt_op;         pend_ff <= nxt_pend;
			rep_ff <= nxt_rep;        cur_ff <= nxt_cur;       end_ff <= nxt_end;
			fail_ff <= nxt_fail;      byte_ff <= nxt_byte;     hsb_ff <= nxt_hsb;
			step_ff <= nxt_step;      frame0_ff <= nxt_frame0;
			frame1_ff <= nxt_frame1;  rdat_ff <= nxt_rdat;
			efirst_ff <= nxt_efirst;  elast_ff <= nxt_elast;   jaddr_ff <= nxt_jaddr;
			space_ff <= nxt_space;    prot_ff <= nxt_prot;     mreq_ff <= nxt_mreq;
			ereq_ff <= nxt_ereq;      wdt_ff <= nxt_wdt;       jump_ff <= nxt_jump;
			slow_ff <= nxt_slow;      resp_ff <= nxt_resp;
		end
	end

	assign prdata      = rdat_ff;
	assign mem_req     = mreq_ff;
	assign mem_space   = space_ff;
	assign mem_addr    = cur_ff;
	assign erase_req   = ereq_ff;
	assign erase_first = efirst_ff;
	assign erase_last  = elast_ff;
	assign wdt_enable  = wdt_ff;
	assign jump_req    = jump_ff;
	assign jump_addr   = jaddr_ff;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	disp_byte_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_ff == ST_UP_IDLE && slow_ff && mreq_ff && mem_ack)
		|=> (prdata == {24'h000000, $past(mem_rdata)}) && pready)
		else $error("display byte not returned");
	blank_fail_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_ff == ST_BUSY && op_ff == OP_BLANK && mreq_ff && mem_ack
		&& mem_rdata != ERASED_BYTE) |=> pend_ff == STAT_NOT_ERASED && fail_ff == $past(cur_ff))
		else $error("blank check failure not recorded");
	cfg_protect_a: assert property (@(posedge pclk) disable iff (!presetn)
		(dn_go && cmd_id == CMD_WRITE && d0 == SUB_01 && d1 <= SEL_CFG_LAST && prot_ff)
		|=> pend_ff == STAT_ERR_WRITE && !$past(cfg_we))
		else $error("protected configuration write not refused");
	read_protect_a: assert property (@(posedge pclk) disable iff (!presetn)
		(dn_go && cmd_id == CMD_READ && d0 == SUB_01 && d1 <= SEL_CFG_LAST && prot_ff)
		|=> pend_ff == STAT_ERR_VENDOR)
		else $error("protected read not refused");
	full_erase_a: assert property (@(posedge pclk) disable iff (!presetn)
		(dn_go && cmd_id == CMD_WRITE && d0 == SUB_00 && d1 == SEL_FULL)
		|=> ##4 erase_req && erase_first == BLK0_FIRST && erase_last == BLK2_LAST && !prot_ff)
		else $error("full erase not issued");
	block_range_a: assert property (@(posedge pclk) disable iff (!presetn)
		(erase_req && erase_first == BLK1_FIRST) |-> erase_last == BLK1_LAST)
		else $error("block one bounds wrong");
	launch_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == ST_LAUNCHED |=> state_ff == ST_LAUNCHED && !mem_req && !erase_req)
		else $error("activity after launch");
	error_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_ff == ST_ERROR && !(req_wr && pwdata[2:0] == REQ_CLRSTAT))
		|=> state_ff == ST_ERROR)
		else $error("error state left without clear");
	wdt_start_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(wdt_enable) |-> state_ff == ST_LAUNCHED && byte_ff == SUB_00)
		else $error("watchdog enabled outside reset launch");

endmodule : dfu_memory_command_interpreter

//--- testbench/flash_mem_model.sv
// Purpose: Behavioural flash, EEPROM and erase engine at the far side of the interpreter.
// Assumes: One read request at a time; read data is valid only with the ack pulse.
// Notes:   Random answer delays; idle data lines toggle so a stale byte never matches.
`timescale 1ns/1ps
module flash_mem_model (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Read port
	input  wire logic        mem_req,
	input  wire logic        mem_space,
	input  wire logic [15:0] mem_addr,
	output logic      [7:0]  mem_rdata,
	output logic             mem_ack,
	// Erase port
	input  wire logic        erase_req,
	output logic             erase_done
);
	int         dly;
	int         ecnt;
	logic [7:0] junk;

	// Page 01xx holds one stray byte so that a blank check has something to find
	function automatic logic [7:0] mdat(input logic sp, input logic [15:0] a);
		if (sp)
			return ~a[7:0];
		if (a[15:8] == 8'h01)
			return (a == 16'h0105) ? 8'h00 : 8'hFF;
		return a[7:0] ^ 8'h5A;
	endfunction : mdat

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mem_ack    <= 1'b0;
			mem_rdata  <= 8'h00;
			erase_done <= 1'b0;
			dly        <= 0;
			ecnt       <= 0;
			junk       <= 8'h00;
		end
		else
		begin
			junk       <= junk + 8'h3B;
			mem_ack    <= 1'b0;
			mem_rdata  <= junk;
			erase_done <= (ecnt == 1);
			ecnt       <= erase_req ? 4 + $urandom_range(6) : (ecnt > 0 ? ecnt - 1 : 0);
			if (mem_req && !mem_ack && dly > 0)
				dly <= dly - 1;
			else if (mem_req && !mem_ack)
			begin
				mem_ack   <= 1'b1;
				mem_rdata <= mdat(mem_space, mem_addr);
				dly       <= $urandom_range(3);
			end
		end
	end
endmodule : flash_mem_model

//--- testbench/dfu_memory_command_interpreter_tb.sv
// Purpose: Self-checking bench of the command interpreter over APB.
// Assumes: Identity parameters keep their defaults.
// Notes:   The driver queues each read expectation; a watcher checks it.
`timescale 1ns/1ps
module dfu_memory_command_interpreter_tb
	import dfu_cmd_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        mem_req, mem_space, mem_ack, erase_req, erase_done, wdt_enable, jump_req;
	logic [7:0]  paddr, mem_rdata, v;
	logic [31:0] pwdata, prdata;
	logic [15:0] mem_addr, erase_first, erase_last, jump_addr, exp_first, exp_last;
	logic [64:0] exp_q[$];
	logic [64:0] note;
	logic [23:0] ids[8] = '{24'h010000, 24'h110001, 24'h220002, 24'h5A0130,
		24'h330131, 24'h440160, 24'h550161, 24'hFF0200};
	int          fails, n_tests, erases, jumps;

	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	dfu_memory_command_interpreter dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_space(mem_space),
		.mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .erase_req(erase_req),
		.erase_first(erase_first), .erase_last(erase_last), .erase_done(erase_done),
		.wdt_enable(wdt_enable), .jump_req(jump_req), .jump_addr(jump_addr));
	flash_mem_model mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
		.mem_space(mem_space), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
		.mem_ack(mem_ack), .erase_req(erase_req), .erase_done(erase_done));

	task check(input logic [32:0] seen, input logic [32:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task complete_run;
		$display("comparisons=%0d mismatches=%0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run

	// Idle cycle before each setup keeps psel from being assigned twice in one step
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 500);
		{psel, penable} <= 2'b00;
		if (n >= 500)
		begin
			fails++;
			complete_run();
		end
	endtask : apb

	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic er);
		exp_q.push_back({er, m, e});
		apb(1'b0, a, 32'h0);
	endtask : rd

	task dnl(input logic [31:0] f0, input logic [15:0] f1, input logic [7:0] len);
		apb(1'b1, REG_FRAME0, f0);
		apb(1'b1, REG_FRAME1, {16'h0, f1});
		apb(1'b1, REG_REQUEST, {16'h0, len, 5'h0, REQ_DNLOAD});
	endtask : dnl

	task cmd(input logic [31:0] f0, input logic [15:0] f1, input logic [7:0] len,
		input logic [3:0] st);
		dnl(f0, f1, len);
		apb(1'b1, REG_REQUEST, {29'h0, REQ_GETSTAT});
		rd(REG_STATUS, 32'hF, {28'h0, st}, 1'b0);
		if (st != STAT_OK && st != STAT_NOT_ERASED)
			apb(1'b1, REG_REQUEST, {29'h0, REQ_CLRSTAT});
	endtask : cmd

	function automatic logic [31:0] fr(input logic [7:0] id, d0, d1, d2);
		return {d2, d1, d0, id};
	endfunction : fr

	always @(posedge pclk)
	begin
		if (psel && penable && pready && !pwrite)
		begin
			note = exp_q.pop_front();
			check({pslverr, prdata & note[63:32]}, {note[64], note[31:0]});
		end
		if (erase_req === 1'b1)
		begin
			erases++;
			check({1'b0, erase_first, erase_last}, {1'b0, exp_first, exp_last});
		end
		if (jump_req === 1'b1)
		begin
			jumps++;
			check({17'h0, jump_addr}, {17'h0, START_ADDR});
		end
	end

	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, presetn} = '0;
		void'($urandom(11));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(REG_STATUS, 32'hFFFF, 32'hFF00, 1'b0);
		rd(8'h20, 32'h0, 32'h0, 1'b1);
		for (int s = 0; s < 7; s++)
		begin
			v = (s == 5) ? 8'hFF : 8'($urandom);
			cmd(fr(CMD_WRITE, SUB_01, 8'(s), v), 16'h0, 8'd6, STAT_OK);
			cmd(fr(CMD_READ, SUB_01, 8'(s), 8'h0), 16'h0, 8'd2, STAT_OK);
			rd(REG_UPLOAD, 32'hFF, {24'h0, v}, 1'b0);
		end
		cmd(fr(CMD_WRITE, SUB_02, SUB_00, 8'h0A), 16'h0, 8'd6, STAT_OK);
		for (int i = 0; i < 8; i++)
		begin
			cmd(fr(CMD_READ, ids[i][15:8], ids[i][7:0], 8'h0), 16'h0, 8'd2, STAT_OK);
			rd(REG_UPLOAD, 32'hFF, (i == 7) ? 32'h0F : {24'h0, ids[i][23:16]}, 1'b0);
		end
		for (int sp = 0; sp < 2; sp++)
		begin
			cmd(fr(CMD_DISPLAY, sp ? SUB_02 : SUB_00, 8'h00, 8'h10), 16'h1300, 8'd6, STAT_OK);
			for (int a = 16'h10; a < 16'h14; a++)
				rd(REG_UPLOAD, 32'hFF, {24'h0, mem.mdat(sp[0], 16'(a))}, 1'b0);
			rd(REG_STATUS, 32'h70, 32'h00, 1'b0);
		end
		cmd(fr(CMD_DISPLAY, SUB_01, 8'h01, 8'h00), 16'h0F01, 8'd6, STAT_NOT_ERASED);
		rd(REG_UPLOAD, 32'hFFFF, 32'h0105, 1'b0);
		dnl(fr(CMD_READ, SUB_00, SUB_00, 8'h0), 16'h0, 8'd2);
		apb(1'b1, REG_REQUEST, {29'h0, REQ_GETSTAT});
		rd(REG_STATUS, 32'h7F, 32'h45, 1'b0);
		apb(1'b1, REG_REQUEST, {29'h0, REQ_CLRSTAT});
		rd(REG_STATUS, 32'h7F, 32'h00, 1'b0);
		cmd(fr(CMD_DISPLAY, SUB_01, 8'h01, 8'h00), 16'h0401, 8'd6, STAT_OK);
		for (int b = 0; b < 3; b++)
		begin
			exp_first = (b == 0) ? BLK0_FIRST : (b == 1) ? BLK1_FIRST : BLK2_FIRST;
			exp_last = (b == 0) ? BLK0_LAST : (b == 1) ? BLK1_LAST : BLK2_LAST;
			v = (b == 0) ? SUB_00 : (b == 1) ? SEL_BLOCK1 : SEL_BLOCK2;
			cmd(fr(CMD_WRITE, SUB_00, v, 8'h0), 16'h0, 8'd2, STAT_OK);
		end
		cmd(fr(CMD_WRITE, SUB_01, 8'h05, 8'h00), 16'h0, 8'd6, STAT_OK);
		rd(REG_STATUS, 32'h80, 32'h80, 1'b0);
		cmd(fr(CMD_READ, SUB_01, SUB_00, 8'h0), 16'h0, 8'd2, STAT_ERR_VENDOR);
		cmd(fr(CMD_WRITE, SUB_01, SUB_00, 8'h12), 16'h0, 8'd6, STAT_ERR_WRITE);
		cmd(fr(CMD_WRITE, SUB_00, SEL_BLOCK1, 8'h0), 16'h0, 8'd2, STAT_ERR_WRITE);
		exp_first = BLK0_FIRST;
		exp_last = BLK2_LAST;
		cmd(fr(CMD_WRITE, SUB_00, SEL_FULL, 8'h0), 16'h0, 8'd2, STAT_OK);
		check(33'(erases), 33'd4);
		for (int i = 0; i < 3; i++)
		begin
			cmd(fr(CMD_READ, SUB_01, (i == 2) ? 8'h05 : 8'(i), 8'h0), 16'h0, 8'd2, STAT_OK);
			rd(REG_UPLOAD, 32'hFF, 32'hFF, 1'b0);
		end
		cmd(fr(8'h07, SUB_00, SUB_00, 8'h0), 16'h0, 8'd2, STAT_ERR_STALL);
		cmd(fr(CMD_WRITE, SUB_01, 8'h07, 8'h33), 16'h0, 8'd6, STAT_ERR_STALL);
		dnl(fr(CMD_WRITE, SUB_03, SUB_00, 8'h0), 16'h0, 8'd3);
		dnl(32'h0, 16'h0, 8'd0);
		repeat (3) @(posedge pclk);
		check({32'h0, wdt_enable}, 33'h1);
		apb(1'b1, REG_REQUEST, {29'h0, REQ_GETSTAT});
		rd(REG_STATUS, 32'h70, 32'h60, 1'b0);
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		dnl(fr(CMD_WRITE, SUB_03, SUB_01, 8'h00), 16'h0, LEN_LONG_JMP);
		dnl(32'h0, 16'h0, 8'd0);
		repeat (3) @(posedge pclk);
		check({jumps[31:0], wdt_enable}, 33'h2);
		complete_run();
	end
endmodule : dfu_memory_command_interpreter_tb
